// File: bench/tbcds_strap_model.sv
`timescale 1ns/100ps
`default_nettype none

// strap pins are driven hard, so pull levels never show
module tbcds_strap_model (
   input wire logic pclk,
   input wire tbcds_pkg::tbcds_straps_t req,
   output logic [9:0] pins,
   output logic resonator_input,
   output logic reference_input
);
   logic [2:0] res_cnt = 3'h0;
   logic [2:0] ref_cnt = 3'h0;

   assign pins = req;

   // unequal half periods, 3 and 7 cycles, so a wrong source shows at once
   always @(posedge pclk) begin
      res_cnt <= (res_cnt == 3'h2) ? 3'h0 : res_cnt + 3'h1;
      ref_cnt <= (ref_cnt == 3'h6) ? 3'h0 : ref_cnt + 3'h1;
      if (res_cnt == 3'h2) begin
         resonator_input <= ~resonator_input;
      end
      if (ref_cnt == 3'h6) begin
         reference_input <= ~reference_input;
      end
   end

   initial begin
      resonator_input = 1'b0;
      reference_input = 1'b0;
   end
endmodule // tbcds_strap_model

`default_nettype wire

// File: bench/two_bank_clock_divider_select_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module two_bank_clock_divider_select_tb_top;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   tbcds_pkg::tbcds_straps_t st;
   logic [9:0] pins;
   logic res_in;
   logic ref_in;
   logic res_drv;
   logic res_q;
   logic res_ok;
   logic a_t, a_c, b0_t, b0_c, b1_t, b1_c;
   logic [1:0] mon;
   logic [31:0] rd;
   logic er;
   int miscompares;
   int check_count;
   int cycles;

   assign mon = {b0_t, a_t};

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   tbcds_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .first_bank_ratio_bit_hi(pins[9]), .first_bank_ratio_bit_lo(pins[8]),
      .second_bank_ratio_bit_hi(pins[7]), .second_bank_ratio_bit_lo(pins[6]),
      .loop_ratio_select(pins[5]), .loop_bypass_n(pins[4]), .reference_source_select(pins[3]),
      .divider_master_clear(pins[2]), .first_bank_output_enable(pins[1]),
      .second_bank_output_enable(pins[0]), .resonator_input(res_in), .resonator_drive(res_drv),
      .reference_input(ref_in), .first_bank_out_true(a_t), .first_bank_out_comp(a_c),
      .second_bank_out0_true(b0_t), .second_bank_out0_comp(b0_c),
      .second_bank_out1_true(b1_t), .second_bank_out1_comp(b1_c));

   tbcds_strap_model u_far (.pclk(pclk), .req(st), .pins(pins), .resonator_input(res_in),
      .reference_input(ref_in));

   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic int ratio(input logic [1:0] c);
      case (c)
         2'h0: return 1;
         2'h1: return 2;
         2'h2: return 4;
         default: return 5;
      endcase
   endfunction

   // one full high run and the low run after it
   task automatic run_len(input int s, input int e);
      int n;
      @(negedge pclk);
      while (mon[s] !== 1'b0) @(negedge pclk);
      while (mon[s] !== 1'b1) @(negedge pclk);
      for (int lv = 1; lv >= 0; lv--) begin
         n = 0;
         while (mon[s] === lv[0]) begin
            n++;
            @(negedge pclk);
         end
         chk(32'(n), 32'(e));
      end
   endtask

   task automatic t_regs;
      apb(1'b0, tbcds_pkg::OFS_STATUS, 32'h0);
      chk(rd, 32'h000036db);
      apb(1'b1, tbcds_pkg::OFS_STATUS, 32'hffffffff);
      apb(1'b0, tbcds_pkg::OFS_STATUS, 32'h0);
      chk({rd[30:0], er}, 32'h00006db6);
      apb(1'b0, tbcds_pkg::OFS_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h0c, 32'h0);
      chk({rd[30:0], er}, 32'h1);
      $display("test regs done");
   endtask

   task automatic t_table;
      run_len(0, 4);
      run_len(1, 5);
      for (int c = 0; c < 4; c++) begin
         @(posedge pclk);
         st.first_bank_ratio <= c[1:0];
         st.second_bank_ratio <= 2'(3 - c);
         repeat (24) @(posedge pclk);
         run_len(0, ratio(c[1:0]));
         run_len(1, ratio(2'(3 - c)));
      end
      $display("test ratios done");
   endtask

   // a 1200 cycle window holds whole wraps of both ratios
   task automatic t_loop;
      logic [15:0] base;
      logic [15:0] d [2];
      for (int f = 0; f < 2; f++) begin
         @(posedge pclk);
         st.loop_ratio_select <= f[0];
         repeat (60) @(posedge pclk);
         apb(1'b0, tbcds_pkg::OFS_LOOP_COUNT, 32'h0);
         base = rd[15:0];
         repeat (1197) @(posedge pclk);
         apb(1'b0, tbcds_pkg::OFS_LOOP_COUNT, 32'h0);
         d[f] = rd[15:0] - base;
      end
      chk(32'(d[0]) * 32'h19, 32'(d[1]) * 32'h18);
      chk(32'(d[0] == 16'h0), 32'h0);
      st.loop_ratio_select <= 1'b0;
      $display("test loop ratio done");
   endtask

   task automatic t_enable(input int s);
      int n;
      @(negedge pclk);
      while (mon[s] !== 1'b0) @(negedge pclk);
      while (mon[s] !== 1'b1) @(negedge pclk);
      @(posedge pclk);
      if (s == 0) st.first_bank_output_enable <= 1'b0;
      else st.second_bank_output_enable <= 1'b0;
      n = 1;
      @(negedge pclk);
      while (mon[s] === 1'b1) begin
         n++;
         @(negedge pclk);
      end
      chk(32'(n), 32'h5);
      repeat (20) begin
         chk(32'(mon[s]), 32'h0);
         @(negedge pclk);
      end
      apb(1'b0, tbcds_pkg::OFS_STATUS, 32'h0);
      chk(32'(rd[12 + s]), 32'h0);
      if (s == 0) st.first_bank_output_enable <= 1'b1;
      else st.second_bank_output_enable <= 1'b1;
      run_len(s, 5);
      $display("test enable done");
   endtask

   // pin clear first, then the soft clear bit
   task automatic t_clear;
      @(posedge pclk);
      for (int m = 0; m < 2; m++) begin
         if (m == 0) st.divider_master_clear <= 1'b1;
         else apb(1'b1, tbcds_pkg::OFS_CTRL, 32'h1);
         repeat (3) @(posedge pclk);
         repeat (8) begin
            @(negedge pclk);
            chk(32'({a_t, a_c, b0_t, b0_c}), 32'h5);
         end
         apb(1'b0, tbcds_pkg::OFS_STATUS, 32'h0);
         chk(32'(rd[11]), 32'h1);
         if (m == 0) st.divider_master_clear <= 1'b0;
         else apb(1'b1, tbcds_pkg::OFS_CTRL, 32'h0);
         run_len(m, 5);
      end
      $display("test clear done");
   endtask

   task automatic t_bypass;
      @(posedge pclk);
      st.first_bank_ratio <= 2'h0;
      st.loop_bypass_n <= 1'b0;
      for (int r = 1; r >= 0; r--) begin
         @(posedge pclk);
         st.reference_source_select <= r[0];
         repeat (30) @(posedge pclk);
         run_len(0, r ? 3 : 7);
      end
      $display("test bypass done");
   endtask

   always @(negedge pclk) begin
      if (presetn === 1'b1) begin
         chk(32'(a_c), 32'(!a_t));
         chk(32'({b1_t, b1_c}), 32'({b0_t, b0_c}));
      end
      if (res_ok === 1'b1) begin
         chk(32'(res_drv), 32'(!res_q));
      end
   end

   // inverter stage registers the level seen before each edge
   always @(posedge pclk) begin
      res_q <= res_in;
      res_ok <= presetn;
   end

   // about 3000 cycles are needed
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         test_done();
      end
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      st = tbcds_pkg::STRAP_DEFAULT;
      miscompares = 0;
      check_count = 0;
      cycles = 0;
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      chk(32'({a_t, a_c, b0_t, b0_c, b1_t, b1_c}), 32'h15);
      @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_table();
      t_loop();
      st.first_bank_ratio <= 2'h3;
      st.second_bank_ratio <= 2'h3;
      repeat (20) @(posedge pclk);
      t_enable(0);
      t_enable(1);
      t_clear();
      t_bypass();
      test_done();
   end
endmodule // two_bank_clock_divider_select_tb_top

`default_nettype wire

// File: rtl/tbcds_bank.sv
`timescale 1ns/100ps
`default_nettype none

module tbcds_bank (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clear,
   input wire logic tick,
   input wire logic [1:0] ratio_sel,
   input wire logic enable,
   output logic out_true,
   output logic out_comp,
   output logic gate_open
);
   logic [2:0] ratio;
   logic [2:0] half_cnt_r;
   logic [2:0] half_cnt_nxt;
   logic raw_r;
   logic raw_nxt;
   logic gate_r;
   logic gate_nxt;

   always_comb begin
      unique case (ratio_sel)
         2'b00: ratio = tbcds_pkg::DIV_BY_1;
         2'b01: ratio = tbcds_pkg::DIV_BY_2;
         2'b10: ratio = tbcds_pkg::DIV_BY_4;
         2'b11: ratio = tbcds_pkg::DIV_BY_5;
      endcase
   end

   // half-period counting
   // toggling every ratio half-periods keeps odd ratios at 50 percent
   always_comb begin
      half_cnt_nxt = half_cnt_r;
      raw_nxt = raw_r;
      if (clear) begin
         half_cnt_nxt = 3'h0;
         raw_nxt = 1'b0;
      end else if (tick) begin
         if (half_cnt_r >= 3'(ratio - 3'h1)) begin
            half_cnt_nxt = 3'h0;
            raw_nxt = ~raw_r;
         end else begin
            half_cnt_nxt = 3'(half_cnt_r + 3'h1);
         end
      end
   end

   assign gate_nxt = raw_nxt ? gate_r : enable;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         half_cnt_r <= 3'h0;
         raw_r <= 1'b0;
      end else begin
         half_cnt_r <= half_cnt_nxt;
         raw_r <= raw_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_r <= 1'b0;
      end else begin
         gate_r <= gate_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_true <= 1'b0;
         out_comp <= 1'b1;
      end else begin
         out_true <= raw_nxt & gate_nxt;
         out_comp <= ~(raw_nxt & gate_nxt);
      end
   end

   assign gate_open = gate_r;

   property p_gate_low_only;
      @(posedge pclk) disable iff (!presetn)
         $changed(gate_r) |-> !raw_r;
   endproperty
   a_gate_low_only: assert property (p_gate_low_only) else $error("gate moved while high");

   property p_div_one;
      @(posedge pclk) disable iff (!presetn)
         (ratio_sel == 2'b00 && tick && !clear) |=> raw_r != $past(raw_r);
   endproperty
   a_div_one: assert property (p_div_one) else $error("divide by 1 missed toggle");

   property p_div_five;
      @(posedge pclk) disable iff (!presetn)
         (ratio_sel == 2'b11 && !clear && tick && half_cnt_r == 3'h3) |=> !$changed(raw_r);
   endproperty
   a_div_five: assert property (p_div_five) else $error("divide by 5 toggled early");

   property p_clear_hold;
      @(posedge pclk) disable iff (!presetn)
         clear |=> (half_cnt_r == 3'h0 && !raw_r && !out_true && out_comp);
   endproperty
   a_clear_hold: assert property (p_clear_hold) else $error("divider not held");

   property p_enabled_follow;
      @(posedge pclk) disable iff (!presetn)
         gate_r && $stable(gate_r) |-> out_true == raw_r;
   endproperty
   a_enabled_follow: assert property (p_enabled_follow) else $error("open gate hides clock");

endmodule // tbcds_bank

`default_nettype wire

// File: rtl/tbcds_top.sv
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

package tbcds_pkg;
   localparam logic [2:0] DIV_BY_1 = 3'h1;
   localparam logic [2:0] DIV_BY_2 = 3'h2;
   localparam logic [2:0] DIV_BY_4 = 3'h4;
   localparam logic [2:0] DIV_BY_5 = 3'h5;
   localparam logic [4:0] LOOP_RATIO_LO = 5'h19;
   localparam logic [4:0] LOOP_RATIO_HI = 5'h18;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_LOOP_COUNT = 8'h08;
   localparam int CTRL_SOFT_CLEAR_BIT = 0;
   localparam logic CTRL_RESET = 1'h0;
   localparam int STATUS_DEFAULT_BIT = 10;
   localparam int STATUS_CLEAR_BIT = 11;
   localparam int STATUS_GATE_A_BIT = 12;
   localparam int STATUS_GATE_B_BIT = 13;

   typedef struct packed {
      logic [1:0] first_bank_ratio;
      logic [1:0] second_bank_ratio;
      logic loop_ratio_select;
      logic loop_bypass_n;
      logic reference_source_select;
      logic divider_master_clear;
      logic first_bank_output_enable;
      logic second_bank_output_enable;
   } tbcds_straps_t;

   // pin levels when every strap is left unconnected
   localparam tbcds_straps_t STRAP_DEFAULT = 10'h2db;
endpackage : tbcds_pkg

module tbcds_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic first_bank_ratio_bit_lo,
   input wire logic first_bank_ratio_bit_hi,
   input wire logic second_bank_ratio_bit_lo,
   input wire logic second_bank_ratio_bit_hi,
   input wire logic loop_ratio_select,
   input wire logic loop_bypass_n,
   input wire logic reference_source_select,
   input wire logic divider_master_clear,
   input wire logic first_bank_output_enable,
   input wire logic second_bank_output_enable,
   input wire logic resonator_input,
   output logic resonator_drive,
   input wire logic reference_input,
   output logic first_bank_out_true,
   output logic first_bank_out_comp,
   output logic second_bank_out0_true,
   output logic second_bank_out0_comp,
   output logic second_bank_out1_true,
   output logic second_bank_out1_comp
);
   tbcds_pkg::tbcds_straps_t straps;
   logic soft_clear_r;
   logic clear;
   logic ref_level;
   logic ref_prev_r;
   logic ref_edge;
   logic vco_tick;
   logic [4:0] loop_limit;
   logic [4:0] loop_cnt_r;
   logic [4:0] loop_cnt_nxt;
   logic [15:0] loop_events_r;
   logic gate_a;
   logic gate_b;
   logic b_true;
   logic b_comp;
   logic setup_phase;
   logic [31:0] rd_nxt;
   logic err_nxt;
   logic [31:0] prdata_r;
   logic pslverr_r;

   assign straps = '{first_bank_ratio: {first_bank_ratio_bit_hi, first_bank_ratio_bit_lo},
                     second_bank_ratio: {second_bank_ratio_bit_hi, second_bank_ratio_bit_lo},
                     loop_ratio_select: loop_ratio_select,
                     loop_bypass_n: loop_bypass_n,
                     reference_source_select: reference_source_select,
                     divider_master_clear: divider_master_clear,
                     first_bank_output_enable: first_bank_output_enable,
                     second_bank_output_enable: second_bank_output_enable};

   assign clear = straps.divider_master_clear | soft_clear_r;

   assign ref_level = straps.reference_source_select ? resonator_input : reference_input;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_prev_r <= 1'b0;
      end else begin
         ref_prev_r <= ref_level;
      end
   end

   // both edges of the reference count, giving half-period ticks
   assign ref_edge = ref_level ^ ref_prev_r;

   // bypass feeds reference edges
   // the loop clock is modelled as pclk toggling: one tick per half period
   assign vco_tick = straps.loop_bypass_n ? 1'b1 : ref_edge;

   // inverting oscillator stage for the resonator
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         resonator_drive <= 1'b1;
      end else begin
         resonator_drive <= ~resonator_input;
      end
   end

   assign loop_limit = straps.loop_ratio_select ? tbcds_pkg::LOOP_RATIO_HI
                                                : tbcds_pkg::LOOP_RATIO_LO;

   // feedback divider only counts while the loop is in use
   always_comb begin
      loop_cnt_nxt = loop_cnt_r;
      if (clear || !straps.loop_bypass_n) begin
         loop_cnt_nxt = 5'h00;
      end else if (vco_tick) begin
         if (loop_cnt_r >= 5'(loop_limit - 5'h01)) begin
            loop_cnt_nxt = 5'h00;
         end else begin
            loop_cnt_nxt = 5'(loop_cnt_r + 5'h01);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loop_cnt_r <= 5'h00;
      end else begin
         loop_cnt_r <= loop_cnt_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loop_events_r <= 16'h0000;
      end else if (clear) begin
         loop_events_r <= 16'h0000;
      end else if (straps.loop_bypass_n && vco_tick && loop_cnt_nxt == 5'h00) begin
         loop_events_r <= 16'(loop_events_r + 16'h0001);
      end
   end

   tbcds_bank u_bank_a (
      .pclk(pclk),
      .presetn(presetn),
      .clear(clear),
      .tick(vco_tick),
      .ratio_sel(straps.first_bank_ratio),
      .enable(straps.first_bank_output_enable),
      .out_true(first_bank_out_true),
      .out_comp(first_bank_out_comp),
      .gate_open(gate_a)
   );

   tbcds_bank u_bank_b (
      .pclk(pclk),
      .presetn(presetn),
      .clear(clear),
      .tick(vco_tick),
      .ratio_sel(straps.second_bank_ratio),
      .enable(straps.second_bank_output_enable),
      .out_true(b_true),
      .out_comp(b_comp),
      .gate_open(gate_b)
   );

   assign second_bank_out0_true = b_true;
   assign second_bank_out0_comp = b_comp;
   assign second_bank_out1_true = b_true;
   assign second_bank_out1_comp = b_comp;

   // zero wait state slave: data is staged in the setup cycle
   assign pready = 1'b1;
   assign setup_phase = psel && !penable;
   assign prdata = prdata_r;
   assign pslverr = pslverr_r;

   always_comb begin
      rd_nxt = 32'h0000_0000;
      err_nxt = 1'b0;
      unique case (paddr)
         tbcds_pkg::OFS_CTRL: begin
            rd_nxt[tbcds_pkg::CTRL_SOFT_CLEAR_BIT] = soft_clear_r;
         end
         tbcds_pkg::OFS_STATUS: begin
            rd_nxt[9:0] = straps;
            rd_nxt[tbcds_pkg::STATUS_DEFAULT_BIT] = (straps == tbcds_pkg::STRAP_DEFAULT);
            rd_nxt[tbcds_pkg::STATUS_CLEAR_BIT] = clear;
            rd_nxt[tbcds_pkg::STATUS_GATE_A_BIT] = gate_a;
            rd_nxt[tbcds_pkg::STATUS_GATE_B_BIT] = gate_b;
         end
         tbcds_pkg::OFS_LOOP_COUNT: begin
            rd_nxt[15:0] = loop_events_r;
         end
         default: begin
            err_nxt = 1'b1;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (setup_phase) begin
         prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
         pslverr_r <= err_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         soft_clear_r <= tbcds_pkg::CTRL_RESET;
      end else if (psel && penable && pwrite && paddr == tbcds_pkg::OFS_CTRL) begin
         soft_clear_r <= pwdata[tbcds_pkg::CTRL_SOFT_CLEAR_BIT];
      end
   end

   property p_bypass_tick;
      @(posedge pclk) disable iff (!presetn)
         (!loop_bypass_n && (reference_source_select ? resonator_input : reference_input)
          == ref_prev_r) |-> !vco_tick;
   endproperty
   a_bypass_tick: assert property (p_bypass_tick) else $error("tick without reference edge");

   property p_source_pick;
      @(posedge pclk) disable iff (!presetn)
         (!loop_bypass_n && !reference_source_select && $changed(reference_input)
          && $stable(reference_source_select)) |-> vco_tick;
   endproperty
   a_source_pick: assert property (p_source_pick) else $error("plain input edge missed");

   property p_loop_wrap;
      @(posedge pclk) disable iff (!presetn)
         (loop_bypass_n && !clear && loop_cnt_r == 5'h17 && $stable(loop_ratio_select))
         |=> ($past(loop_ratio_select) ? loop_cnt_r == 5'h00 : loop_cnt_r == 5'h18);
   endproperty
   a_loop_wrap: assert property (p_loop_wrap) else $error("loop ratio wrong");

   property p_clear_outputs;
      @(posedge pclk) disable iff (!presetn)
         divider_master_clear |=> (!first_bank_out_true && first_bank_out_comp
                                   && !second_bank_out1_true && second_bank_out1_comp);
   endproperty
   a_clear_outputs: assert property (p_clear_outputs) else $error("outputs not parked");

   property p_pairs_match;
      @(posedge pclk) disable iff (!presetn)
         second_bank_out0_true == second_bank_out1_true
         && second_bank_out0_comp == !second_bank_out0_true;
   endproperty
   a_pairs_match: assert property (p_pairs_match) else $error("second bank pairs differ");

   property p_runs;
      @(posedge pclk) disable iff (!presetn)
         (!clear && loop_bypass_n && first_bank_output_enable && gate_a
          && first_bank_ratio_bit_hi == 1'b0 && first_bank_ratio_bit_lo == 1'b0)[*2]
         |=> $changed(first_bank_out_true);
   endproperty
   a_runs: assert property (p_runs) else $error("first bank not toggling");

   property p_slverr;
      @(posedge pclk) disable iff (!presetn)
         (psel && !penable && paddr == 8'h0c) |=> pslverr;
   endproperty
   a_slverr: assert property (p_slverr) else $error("unmapped address accepted");

   property p_b_disabled;
      @(posedge pclk) disable iff (!presetn)
         (!gate_b) |-> (!second_bank_out0_true && second_bank_out0_comp);
   endproperty
   a_b_disabled: assert property (p_b_disabled) else $error("closed bank toggles");

   // first edge after reset compares against a cleared history register
   property p_res_pick;
      @(posedge pclk) disable iff (!presetn)
         (!loop_bypass_n && reference_source_select && $changed(resonator_input)
          && $stable(reference_source_select) && $past(presetn)) |-> vco_tick;
   endproperty
   a_res_pick: assert property (p_res_pick) else $error("resonator edge lost");

   property p_soft_clear;
      @(posedge pclk) disable iff (!presetn)
         soft_clear_r |=> (!first_bank_out_true && first_bank_out_comp
                           && !second_bank_out0_true && second_bank_out0_comp);
   endproperty
   a_soft_clear: assert property (p_soft_clear) else $error("soft clear ignored");

   property p_a_closed;
      @(posedge pclk) disable iff (!presetn)
         (!gate_a) |-> (!first_bank_out_true && first_bank_out_comp);
   endproperty
   a_a_closed: assert property (p_a_closed) else $error("closed bank a toggles");

   property p_loop_clear;
      @(posedge pclk) disable iff (!presetn)
         clear |=> (loop_events_r == 16'h0000 && loop_cnt_r == 5'h00);
   endproperty
   a_loop_clear: assert property (p_loop_clear) else $error("loop count kept");

   property p_byp_idle;
      @(posedge pclk) disable iff (!presetn)
         !loop_bypass_n |=> loop_cnt_r == 5'h00;
   endproperty
   a_byp_idle: assert property (p_byp_idle) else $error("loop ran in bypass");

   property p_drive_inv;
      @(posedge pclk) disable iff (!presetn)
         $past(presetn) |-> resonator_drive == !$past(resonator_input);
   endproperty
   a_drive_inv: assert property (p_drive_inv) else $error("drive not inverted");

endmodule // tbcds_top

`default_nettype wire
